// ===== verilog/ecc_report_map.svh
// Purpose: Register offsets, field positions and reset values of the segment check report block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Included by bare name
`ifndef ECC_REPORT_MAP_SVH
`define ECC_REPORT_MAP_SVH
`define ECC_REPORT_BASE 8'h00
`define ECC_EXPECT_BASE 8'h20
`define ECC_STATUS_OFF 8'h40
`define ECC_BIT_OFF_POS 0
`define ECC_BYTE_IDX_POS 3
`define ECC_PARITY_POS 12
`define ECC_EXP_TOTAL_POS 11
`define ECC_ST_SINGLE_POS 0
`define ECC_ST_MULTI_POS 8
`define ECC_ST_TOTAL_POS 16
`define ECC_ST_MODE_POS 24
`define ECC_EXPECT_RESET 12'h000
`define ECC_ACC_RESET 11'h000
`endif

// ===== verilog/ecc_report_pkg.sv
// Purpose: Shared types of the segment check report block
// Assumes: Offsets and positions live in ecc_report_map.svh
// Notes: Location word is byte index above bit offset
package ecc_report_pkg;
  typedef logic [10:0] loc_t;
  typedef logic [11:0] expect_t;
  typedef enum {RK_REPORT, RK_EXPECT, RK_STATUS, RK_NONE} reg_kind_e;
endpackage : ecc_report_pkg

// ===== verilog/seg_parity_accum.sv
// Purpose: Running parity of one 256-byte segment
// Assumes: Bytes arrive with their index inside the segment
// Notes: XOR of the addresses of all set bits plus overall parity
`timescale 1ns/1ps
`include "ecc_report_map.svh"
module seg_parity_accum (
  input wire logic clk,
  input wire logic srst,
  input wire logic clear,
  input wire logic byte_valid,
  input wire logic [7:0] byte_index,
  input wire logic [7:0] byte_data,
  output ecc_report_pkg::loc_t acc_parity,
  output logic acc_total
);
  // A single flipped bit moves this XOR by exactly its own address
  function automatic ecc_report_pkg::loc_t addr_xor(input logic [7:0] idx, input logic [7:0] d);
    ecc_report_pkg::loc_t r;
    r = `ECC_ACC_RESET;
    for (int b = 0; b < 8; b++)
    begin
      if (d[b])
        r = r ^ {idx, 3'(b)};
    end
    return r;
  endfunction : addr_xor

  always_ff @(posedge clk)
  begin
    if (srst || clear)
    begin
      acc_parity <= `ECC_ACC_RESET;
      acc_total <= 1'b0;
    end
    else if (byte_valid)
    begin
      acc_parity <= acc_parity ^ addr_xor(byte_index, byte_data);
      acc_total <= acc_total ^ (^byte_data);
    end
  end
endmodule : seg_parity_accum

// ===== verilog/nand_segment_ecc_report.sv
// Purpose: Check report registers for page segments 3 to 8, one code per 256 bytes
// Assumes: Page bytes come from same-clock flash logic with their page offset
// Notes: Software reloads stored parity into the expected registers before a read
//
// Summary of operation
// - Single error: report flipped bit offset
// - Single error: report faulty byte index
// - Multiple errors: location fields carry nothing valid
// - Segments 3-7 each cover next 256 bytes
// - Segment 8 covers bytes 2048 to 2303
`timescale 1ns/1ps
`include "ecc_report_map.svh"
module nand_segment_ecc_report #(
  parameter int FIRST_SEG = 3,
  parameter int SEGS = 6
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic page_start,
  input wire logic page_read,
  input wire logic page_end,
  input wire logic data_valid,
  input wire logic [11:0] data_addr,
  input wire logic [7:0] data_byte
);
  // Segment number comes from a 4-bit nibble; report words must fit below the expected block
  if (FIRST_SEG < 0 || FIRST_SEG + SEGS > 16 || SEGS < 1 || SEGS > 8)
  begin : g_bad_range
    $error("Segment range not supported");
  end

  ecc_report_pkg::loc_t acc_parity [SEGS];
  logic [SEGS-1:0] acc_total;
  ecc_report_pkg::expect_t expect_reg [SEGS];
  ecc_report_pkg::loc_t loc_reg [SEGS];
  logic [SEGS-1:0] single_reg;
  logic [SEGS-1:0] multi_reg;
  logic read_mode_reg;
  logic [31:0] rdata_next;
  ecc_report_pkg::reg_kind_e kind;
  int unsigned sel;

  // Upper nibble of the page offset picks the segment
  function automatic logic seg_hit(input logic [11:0] addr, input int idx);
    return addr[11:8] == 4'(FIRST_SEG + idx);
  endfunction : seg_hit

  function automatic ecc_report_pkg::reg_kind_e decode(input logic [7:0] a, output int unsigned i);
    i = 0;
    if (a[1:0] != 2'h0)
      return ecc_report_pkg::RK_NONE;
    if (a >= `ECC_REPORT_BASE && a < `ECC_REPORT_BASE + 8'(4 * SEGS))
    begin
      i = 32'(a - `ECC_REPORT_BASE) >> 2;
      return ecc_report_pkg::RK_REPORT;
    end
    if (a >= `ECC_EXPECT_BASE && a < `ECC_EXPECT_BASE + 8'(4 * SEGS))
    begin
      i = 32'(a - `ECC_EXPECT_BASE) >> 2;
      return ecc_report_pkg::RK_EXPECT;
    end
    if (a == `ECC_STATUS_OFF)
      return ecc_report_pkg::RK_STATUS;
    return ecc_report_pkg::RK_NONE;
  endfunction : decode

  genvar g;
  generate
    for (g = 0; g < SEGS; g++)
    begin : g_seg
      seg_parity_accum u_acc (
        .clk(clk),
        .srst(srst),
        .clear(page_start),
        .byte_valid(data_valid && seg_hit(data_addr, g)),
        .byte_index(data_addr[7:0]),
        .byte_data(data_byte),
        .acc_parity(acc_parity[g]),
        .acc_total(acc_total[g])
      );

      // A lone error flips overall parity; two errors keep it but leave a syndrome
      always_ff @(posedge clk)
      begin
        if (srst || page_start)
        begin
          loc_reg[g] <= `ECC_ACC_RESET;
          single_reg[g] <= 1'b0;
          multi_reg[g] <= 1'b0;
        end
        else if (page_end && read_mode_reg)
        begin
          loc_reg[g] <= acc_parity[g] ^ expect_reg[g][10:0];
          single_reg[g] <= acc_total[g] ^ expect_reg[g][`ECC_EXP_TOTAL_POS];
          multi_reg[g] <= !(acc_total[g] ^ expect_reg[g][`ECC_EXP_TOTAL_POS])
            && (acc_parity[g] != expect_reg[g][10:0]);
        end
      end

      always_ff @(posedge clk)
      begin
        if (srst)
          expect_reg[g] <= `ECC_EXPECT_RESET;
        else if (psel && penable && pready && pwrite && kind == ecc_report_pkg::RK_EXPECT
                 && sel == g)
          expect_reg[g] <= pwdata[11:0];
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (srst)
      read_mode_reg <= 1'b0;
    else if (page_start)
      read_mode_reg <= page_read;
  end

  // Location field is zero outside a read; after a multiple error it is a raw syndrome
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    kind = decode(paddr, sel);
    case (kind)
      ecc_report_pkg::RK_REPORT:
      begin
        rdata_next = (32'(acc_parity[sel]) << `ECC_PARITY_POS)
          | (read_mode_reg ? 32'(loc_reg[sel]) : 32'h0000_0000);
      end
      ecc_report_pkg::RK_EXPECT:
        rdata_next = 32'(expect_reg[sel]);
      ecc_report_pkg::RK_STATUS:
      begin
        rdata_next = (32'(single_reg) << `ECC_ST_SINGLE_POS)
          | (32'(multi_reg) << `ECC_ST_MULTI_POS)
          | (32'(acc_total) << `ECC_ST_TOTAL_POS)
          | (32'(read_mode_reg) << `ECC_ST_MODE_POS);
      end
      default:
        rdata_next = 32'h0000_0000;
    endcase
  end

  // Data captured in setup so the access phase answers with no wait state
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable && !pready;
      pslverr <= psel && !penable && !pready && kind == ecc_report_pkg::RK_NONE;
      if (psel && !penable && !pwrite)
        prdata <= rdata_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_bit_offset_set: assert property (page_end && read_mode_reg && !page_start |=>
    loc_reg[0][2:0] == $past(acc_parity[0][2:0] ^ expect_reg[0][2:0]))
    else $error("Bit offset not latched from syndrome");
  a_byte_index_set: assert property (page_end && read_mode_reg && !page_start |=>
    loc_reg[SEGS-1][10:3] == $past(acc_parity[SEGS-1][10:3] ^ expect_reg[SEGS-1][10:3]))
    else $error("Byte index not latched from syndrome");
  a_multi_excl_single: assert property (page_end && read_mode_reg && !page_start
    && acc_total[0] == expect_reg[0][11] && acc_parity[0] != expect_reg[0][10:0]
    |=> multi_reg[0] && !single_reg[0])
    else $error("Multiple error not flagged");
  a_seg3_slice: assert property (data_valid && !page_start && data_addr >= 12'h300
    && data_addr <= 12'h3FF |=> acc_total[0] == $past(acc_total[0] ^ (^data_byte)))
    else $error("Segment 3 slice not accumulated");
  a_seg8_slice: assert property (data_valid && !page_start && data_addr >= 12'h800
    && data_addr <= 12'h8FF |=> acc_total[5] == $past(acc_total[5] ^ (^data_byte)))
    else $error("Segment 8 slice not accumulated");
  a_report_layout: assert property (psel && !penable && !pwrite && paddr == 8'h00
    |=> prdata[11] == 1'b0 && prdata[31:23] == 9'h000
    && prdata[22:12] == $past(acc_parity[0]))
    else $error("Report word layout wrong");

  // Bus handshake, flags and hidden location checks
  a_ready_after_setup: assert property (psel && !penable && !pready |=> pready)
    else $error("No access phase answer after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("Ready held longer than one cycle");
  a_err_misaligned: assert property (psel && !penable && !pready && paddr[1:0] != 2'h0
    |=> pslverr)
    else $error("Misaligned access not refused");
  a_unmapped_zero: assert property (psel && !penable && !pready && !pwrite
    && paddr == `ECC_STATUS_OFF + 8'h04 |=> prdata == 32'h0000_0000 && pslverr)
    else $error("Unmapped read not refused");
  a_single_flag: assert property (page_end && read_mode_reg && !page_start
    && acc_total[1] != expect_reg[1][11] |=> single_reg[1] && !multi_reg[1])
    else $error("Single error not flagged");
  a_loc_hidden_program: assert property (psel && !penable && !pwrite && paddr == 8'h14
    && !read_mode_reg |=> prdata[10:0] == 11'h000)
    else $error("Location shown outside a page read");
  a_expect_written: assert property (psel && penable && pready && pwrite
    && paddr == `ECC_EXPECT_BASE + 8'h04 |=> expect_reg[1] == $past(pwdata[11:0]))
    else $error("Expected parity write lost");
  a_page_clears: assert property (page_start |=> !single_reg[0] && !multi_reg[0]
    && acc_total[0] == 1'b0)
    else $error("Page start did not clear segment state");
  c_expect_write: cover property (psel && penable && pready && pwrite && !pslverr);
  c_single_error: cover property (page_end && read_mode_reg ##1 single_reg[0]);
  c_multi_error: cover property (page_end && read_mode_reg ##1 multi_reg[0]);
  c_report_read: cover property (psel && penable && pready && !pwrite && !pslverr);
endmodule : nand_segment_ecc_report

// ===== dv/flash_page_model.sv
// Purpose: Flash side model streaming page bytes into the report block
// Assumes: Same clock, one byte per cycle
// Notes: Data lines show the inverse of the last byte between strobes
`timescale 1ns/1ps
module flash_page_model (
  input wire logic clk,
  output logic page_start,
  output logic page_read,
  output logic page_end,
  output logic data_valid,
  output logic [11:0] data_addr,
  output logic [7:0] data_byte
);
  initial
  begin
    page_start = 1'b0;
    page_read = 1'b0;
    page_end = 1'b0;
    data_valid = 1'b0;
    data_addr = 12'h000;
    data_byte = 8'h00;
  end
  task automatic run_page(input logic rd, input logic [11:0] a0, input logic [7:0] d0,
    input logic [11:0] a1, input logic [7:0] d1);
    @(posedge clk);
    page_start <= 1'b1;
    page_read <= rd;
    @(posedge clk);
    page_start <= 1'b0;
    data_valid <= 1'b1;
    data_addr <= a0;
    data_byte <= d0;
    @(posedge clk);
    data_addr <= a1;
    data_byte <= d1;
    @(posedge clk);
    data_valid <= 1'b0;
    data_byte <= ~d1;
    page_end <= 1'b1;
    @(posedge clk);
    page_end <= 1'b0;
    @(posedge clk);
  endtask : run_page
endmodule : flash_page_model

// ===== dv/nand_segment_ecc_report_test.sv
// Purpose: Self-checking bench for the segment check report block
// Assumes: APB slave answers in its own time, flash bytes from the partner model
// Notes: Expected parity is zero, so the syndrome is the running parity
`timescale 1ns/1ps
module nand_segment_ecc_report_test;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, page_start, page_read, page_end, data_valid;
  logic [11:0] data_addr;
  logic [7:0] data_byte;
  int bad_count = 0;
  int tests_run = 0;
  always #10 clk = ~clk;
  nand_segment_ecc_report u_nand_segment_ecc_report (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .page_start(page_start), .page_read(page_read),
    .page_end(page_end), .data_valid(data_valid), .data_addr(data_addr),
    .data_byte(data_byte));
  flash_page_model u_flash_page_model (.clk(clk), .page_start(page_start),
    .page_read(page_read), .page_end(page_end), .data_valid(data_valid),
    .data_addr(data_addr), .data_byte(data_byte));
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  // Request held until pready is sampled high; bench timeout ends a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rchk(input string w, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(w, e, rd);
    chk({w, " err"}, 32'h00000000, {31'h00000000, err});
  endtask : rchk
  task automatic program_page;
    rchk("seg3 reset", 8'h00, 32'h00000000);
    u_flash_page_model.run_page(1'b0, 12'h305, 8'h08, 12'h8FF, 8'h01);
    rchk("seg3 report", 8'h00, 32'h0002B000);
    rchk("seg8 report", 8'h14, 32'h007F8000);
    rchk("status", 8'h40, 32'h00210000);
    apb(1'b1, 8'h14, 32'hFFFFFFFF);
    rchk("seg8 kept", 8'h14, 32'h007F8000);
  endtask : program_page
  task automatic single_error;
    apb(1'b1, 8'h24, 32'hFFFFFFFF);
    rchk("seg4 expected", 8'h24, 32'h00000FFF);
    apb(1'b1, 8'h24, 32'h00000000);
    u_flash_page_model.run_page(1'b1, 12'h2FF, 8'hFF, 12'h412, 8'h40);
    rchk("seg3 report", 8'h00, 32'h00000000);
    rchk("seg4 report", 8'h04, 32'h00096096);
    rchk("status", 8'h40, 32'h01020002);
  endtask : single_error
  task automatic multi_error;
    u_flash_page_model.run_page(1'b1, 12'h500, 8'h03, 12'h7FF, 8'h80);
    rchk("seg7 report", 8'h10, 32'h007FF7FF);
    rchk("status", 8'h40, 32'h01100410);
  endtask : multi_error
  task automatic bad_access;
    apb(1'b0, 8'h44, 32'h00000000);
    chk("unmapped err", 32'h00000001, {31'h00000000, err});
    chk("unmapped data", 32'h00000000, rd);
    apb(1'b0, 8'h02, 32'h00000000);
    chk("misaligned err", 32'h00000001, {31'h00000000, err});
  endtask : bad_access
  initial
  begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    program_page();
    single_error();
    multi_error();
    bad_access();
    close_out();
  end
  initial
  begin
    #200000;
    bad_count++;
    close_out();
  end
endmodule : nand_segment_ecc_report_test
